// ===== gpost_top.sv
// Output strobe assignment register and sequencer output control
`timescale 1ns/100ps
module gpost_top
    import gpost_pkg::*;
#(
    parameter int STEP_CYCLES_P = STEP_CYCLES
) (
    input  wire logic       clk_sys_in,
    input  wire logic       rstn_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    input  wire logic       pw_unlocked_in,
    input  wire logic       nv_load_in,
    input  wire logic [7:0] nv_data_in,
    input  wire logic       seq_start_in,
    input  wire logic       seq_down_in,
    input  wire logic       out1_manual_in,
    input  wire logic       out3_manual_in,
    output logic [7:0]      reg_rdata_out,
    output logic            reg_rvalid_out,
    output logic            wr_refused_out,
    output logic            nv_store_req_out,
    output logic            general_output_one_out,
    output logic            general_output_three_out,
    output logic            out1_seq_ctl_out,
    output logic            out3_seq_ctl_out,
    output logic            seq_busy_out,
    output logic            seq_done_out
);

    typedef struct packed {
        logic [7:0] assign_q;
        logic [7:0] rdata;
        logic       rvalid;
        logic       refused;
        logic       nv_req;
        logic       out1;
        logic       out3;
        logic       ctl1;
        logic       ctl3;
        logic       busy;
        logic       done;
    } gpost_state_t;

    gpost_state_t s_reg;
    gpost_state_t s_next;

    logic [3:0] step_idx;
    logic       step_strobe;
    logic       step_busy;
    logic       step_done;
    logic       hit;
    logic       wr_ok;
    logic [3:0] sel1;
    logic [3:0] sel3;

    ////////////////////////////////////////////////////////////////////////
    // Strobe stepper

    gpost_stepper #(
        .STEP_CYCLES_P (STEP_CYCLES_P)
    ) u_stepper (
        .clk_sys_in (clk_sys_in),
        .rstn_in    (rstn_in),
        .start_in   (seq_start_in),
        .abort_in   (seq_down_in),
        .idx_out    (step_idx),
        .strobe_out (step_strobe),
        .busy_out   (step_busy),
        .done_out   (step_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register access and output control

    assign hit   = (reg_addr_in == ASSIGN_ADDR);
    // RULE1: writes need unlock
    assign wr_ok = reg_wr_in && hit && pw_unlocked_in;
    assign sel1  = s_reg.assign_q[OUT1_LSB +: FIELD_W];
    assign sel3  = s_reg.assign_q[OUT3_LSB +: FIELD_W];

    always_comb begin
        s_next         = s_reg;
        s_next.rvalid  = reg_rd_in;
        s_next.refused = reg_wr_in && hit && !pw_unlocked_in;
        s_next.nv_req  = wr_ok;
        s_next.busy    = step_busy;
        s_next.done    = step_done;
        s_next.rdata   = hit ? s_reg.assign_q : 8'h00;
        if (!reg_rd_in) begin
            s_next.rdata = s_reg.rdata;
        end
        // RULE2: backed fields reload
        if (nv_load_in) begin
            s_next.assign_q = nv_data_in;
        // RULE3: software field write
        end else if (wr_ok) begin
            s_next.assign_q = reg_wdata_in;
        end
        // RULE5: uncontrolled codes
        s_next.ctl1 = gpost_code_ctl(sel1);
        s_next.ctl3 = gpost_code_ctl(sel3);
        if (!s_next.ctl1) begin
            s_next.out1 = out1_manual_in;
        end else if (seq_down_in) begin
            s_next.out1 = 1'b0;
        // RULE4: assert at matching strobe
        end else if (step_strobe && step_idx == sel1) begin
            s_next.out1 = 1'b1;
        end
        if (!s_next.ctl3) begin
            s_next.out3 = out3_manual_in;
        end else if (seq_down_in) begin
            s_next.out3 = 1'b0;
        end else if (step_strobe && step_idx == sel3) begin
            s_next.out3 = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            s_reg <= '{assign_q: ASSIGN_RST, rdata: 8'h00, rvalid: 1'b0,
                       refused: 1'b0, nv_req: 1'b0, out1: 1'b0,
                       out3: 1'b0, ctl1: 1'b0, ctl3: 1'b0, busy: 1'b0,
                       done: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata_out            = s_reg.rdata;
    assign reg_rvalid_out           = s_reg.rvalid;
    assign wr_refused_out           = s_reg.refused;
    assign nv_store_req_out         = s_reg.nv_req;
    assign general_output_one_out   = s_reg.out1;
    assign general_output_three_out = s_reg.out3;
    assign out1_seq_ctl_out         = s_reg.ctl1;
    assign out3_seq_ctl_out         = s_reg.ctl3;
    assign seq_busy_out             = s_reg.busy;
    assign seq_done_out             = s_reg.done;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    reset_value_a: assert property ( // RULE1
        @(posedge clk_sys_in) disable iff (!rstn_in)
        $past(!rstn_in) |-> s_reg.assign_q == ASSIGN_RST)
        else $error("assignment register not at reset value");

    locked_write_a: assert property ( // RULE1
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (reg_wr_in && hit && !pw_unlocked_in && !nv_load_in)
        |=> $stable(s_reg.assign_q) && wr_refused_out && !nv_store_req_out)
        else $error("locked write changed the register");

    out3_field_a: assert property ( // RULE2
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (wr_ok && !nv_load_in)
        |=> sel3 == $past(reg_wdata_in[7:4]) && nv_store_req_out)
        else $error("output three field not written");

    out1_readback_a: assert property ( // RULE3
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (wr_ok && !nv_load_in) ##1 (reg_rd_in && hit && !nv_load_in)
        |=> reg_rvalid_out && reg_rdata_out[3:0] == $past(reg_wdata_in[3:0], 2))
        else $error("output one field read back wrong");

    strobe_assert_a: assert property ( // RULE4
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (step_strobe && gpost_code_ctl(sel1) && step_idx == sel1
         && !seq_down_in && !nv_load_in && !wr_ok)
        |=> general_output_one_out && out1_seq_ctl_out)
        else $error("output one missed its strobe");

    uncontrolled_a: assert property ( // RULE5
        @(posedge clk_sys_in) disable iff (!rstn_in)
        !gpost_code_ctl(sel3)
        |=> general_output_three_out == $past(out3_manual_in)
            && !out3_seq_ctl_out)
        else $error("uncontrolled output three was driven");

    // A fresh run reloads the first index, so only steps within a run count
    ascending_idx_a: assert property ( // RULE7
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (step_busy && $past(step_busy) && $changed(step_idx))
        |-> step_idx == $past(step_idx) + 4'h1)
        else $error("strobe index did not step upward");

    strobe_range_a: assert property ( // RULE7
        @(posedge clk_sys_in) disable iff (!rstn_in)
        step_strobe |-> step_busy && gpost_code_ctl(step_idx))
        else $error("strobe outside a run or index out of range");

    out3_strobe_a: assert property ( // RULE4
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (step_strobe && gpost_code_ctl(sel3) && step_idx == sel3
         && !seq_down_in)
        |=> general_output_three_out && out3_seq_ctl_out)
        else $error("output three missed its strobe");

    seq_down_a: assert property ( // RULE4
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (seq_down_in && gpost_code_ctl(sel1))
        |=> !general_output_one_out)
        else $error("output one not released by power-down");

    out1_manual_a: assert property ( // RULE5
        @(posedge clk_sys_in) disable iff (!rstn_in)
        !gpost_code_ctl(sel1)
        |=> general_output_one_out == $past(out1_manual_in)
            && !out1_seq_ctl_out)
        else $error("uncontrolled output one was driven");

    other_read_a: assert property ( // RULE1
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (reg_rd_in && !hit)
        |=> reg_rvalid_out && reg_rdata_out == 8'h00)
        else $error("read of another address returned data");

    rdata_hold_a: assert property ( // RULE1
        @(posedge clk_sys_in) disable iff (!rstn_in)
        !reg_rd_in |=> $stable(reg_rdata_out) && !reg_rvalid_out)
        else $error("read data moved without a read");

endmodule

// ===== gpost_pkg.sv
// Constants, types and helpers for the output strobe assignment block
// Summary of operation
// RULE1: Assignment register at subaddress 0x26, reset 0x3, writes only when unlocked.
// RULE2: Bits 7-4 select strobe for output three, read/write, backed, reset 0h.
// RULE3: Bits 3-0 select strobe for output one, read/write, backed, reset 3h.
// RULE4: Codes 3h to Ah assert the output at strobe equal to code.
// RULE5: Codes 0h-2h and Bh-Fh leave the output outside sequencer control.
// RULE6: Host ignores the freshness seal flag when backup supplies are disabled.
// RULE7: Strobe index steps upward; matching outputs assert at their index.
package gpost_pkg;

    localparam logic [7:0] ASSIGN_ADDR   = 8'h26;
    localparam int         FIELD_W       = 4;
    localparam int         OUT3_LSB      = 4;
    localparam int         OUT1_LSB      = 0;
    localparam logic [3:0] OUT3_RST      = 4'h0;
    localparam logic [3:0] OUT1_RST      = 4'h3;
    localparam logic [7:0] ASSIGN_RST    = {OUT3_RST, OUT1_RST};
    localparam logic [3:0] STROBE_FIRST  = 4'h3;
    localparam logic [3:0] STROBE_LAST   = 4'ha;

    localparam int CLK_PERIOD_PS = 4000;
    localparam int STEP_TIME_NS  = 1000;
    localparam int STEP_CYCLES   = (STEP_TIME_NS * 1000 / CLK_PERIOD_PS) < 1
                                   ? 1 : STEP_TIME_NS * 1000 / CLK_PERIOD_PS;

    typedef enum logic [1:0] {
        GPOST_IDLE = 2'b00,
        GPOST_RUN  = 2'b01,
        GPOST_DONE = 2'b11
    } gpost_step_t;

    // True when a field code places its output under sequencer control
    function automatic logic gpost_code_ctl(input logic [3:0] code);
        return (code >= STROBE_FIRST) && (code <= STROBE_LAST);
    endfunction

endpackage

// ===== gpost_stepper.sv
// Power-up strobe index stepper
`timescale 1ns/100ps
module gpost_stepper
    import gpost_pkg::*;
#(
    parameter int STEP_CYCLES_P = STEP_CYCLES
) (
    input  wire logic       clk_sys_in,
    input  wire logic       rstn_in,
    input  wire logic       start_in,
    input  wire logic       abort_in,
    output logic [3:0]      idx_out,
    output logic            strobe_out,
    output logic            busy_out,
    output logic            done_out
);

    typedef struct packed {
        gpost_step_t st;
        logic [3:0]  idx;
        logic [15:0] cnt;
        logic        strobe;
    } gpost_stp_state_t;

    localparam logic [15:0] CNT_LAST = 16'(STEP_CYCLES_P - 1);

    gpost_stp_state_t s_reg;
    gpost_stp_state_t s_next;

    always_comb begin
        s_next        = s_reg;
        s_next.strobe = 1'b0;
        case (s_reg.st)
            GPOST_IDLE: begin
                if (start_in) begin
                    s_next.st  = GPOST_RUN;
                    s_next.idx = STROBE_FIRST;
                    s_next.cnt = '0;
                end
            end
            GPOST_RUN: begin
                if (abort_in) begin
                    s_next.st = GPOST_IDLE;
                // RULE7: ascending index steps
                end else if (s_reg.strobe) begin
                    if (s_reg.idx == STROBE_LAST) begin
                        s_next.st = GPOST_DONE;
                    end else begin
                        s_next.idx = s_reg.idx + 4'h1;
                    end
                end else if (s_reg.cnt == CNT_LAST) begin
                    s_next.cnt    = '0;
                    s_next.strobe = 1'b1;
                end else begin
                    s_next.cnt = s_reg.cnt + 16'h0001;
                end
            end
            GPOST_DONE: begin
                if (abort_in) begin
                    s_next.st = GPOST_IDLE;
                end
            end
            default: begin
                s_next.st = GPOST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            s_reg <= '{st: GPOST_IDLE, idx: 4'h0, cnt: 16'h0000,
                       strobe: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign idx_out    = s_reg.idx;
    assign strobe_out = s_reg.strobe;
    assign busy_out   = (s_reg.st == GPOST_RUN);
    assign done_out   = (s_reg.st == GPOST_DONE);

endmodule

// ===== gpost_top_bench.sv
// Self-checking bench for the output strobe assignment block
`timescale 1ns/100ps
module gpost_top_bench;
    import gpost_pkg::*;
    localparam int STEP_P = 4;
    logic       clk_sys_in, rstn_in, reg_wr_in, reg_rd_in;
    logic       pw_unlocked_in, nv_load_in, seq_start_in, seq_down_in;
    logic       out1_manual_in, out3_manual_in;
    logic [7:0] reg_addr_in, reg_wdata_in, nv_data_in, reg_rdata_out;
    logic       reg_rvalid_out, wr_refused_out, nv_store_req_out;
    logic       general_output_one_out, general_output_three_out;
    logic       out1_seq_ctl_out, out3_seq_ctl_out;
    logic       seq_busy_out, seq_done_out;
    int         n_errors, checks, c, t1, t3, k;

    gpost_top #(.STEP_CYCLES_P(STEP_P)) dut (
        .clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .pw_unlocked_in(pw_unlocked_in), .nv_load_in(nv_load_in),
        .nv_data_in(nv_data_in), .seq_start_in(seq_start_in),
        .seq_down_in(seq_down_in), .out1_manual_in(out1_manual_in),
        .out3_manual_in(out3_manual_in), .reg_rdata_out(reg_rdata_out),
        .reg_rvalid_out(reg_rvalid_out), .wr_refused_out(wr_refused_out),
        .nv_store_req_out(nv_store_req_out),
        .general_output_one_out(general_output_one_out),
        .general_output_three_out(general_output_three_out),
        .out1_seq_ctl_out(out1_seq_ctl_out),
        .out3_seq_ctl_out(out3_seq_ctl_out),
        .seq_busy_out(seq_busy_out), .seq_done_out(seq_done_out));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end

    task automatic conclude;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic check1(input logic seen, input logic exp);
        check({7'h00, seen}, {7'h00, exp});
    endtask

    task automatic timeout;
        n_errors++;
        $display("[ERR] %0t wait ran out", $time);
        conclude();
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask

    task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp);
        int i;
        reg_addr_in = addr;
        reg_rd_in = 1'b1;
        tick(1);
        reg_rd_in = 1'b0;
        for (i = 0; i < 4 && reg_rvalid_out !== 1'b1; i++) tick(1);
        if (reg_rvalid_out !== 1'b1) timeout();
        check(reg_rdata_out, exp);
    endtask

    // Response code: 01 stored, 10 refused, 00 silently ignored
    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data,
                             input logic [1:0] rsp);
        int i;
        reg_addr_in = addr;
        reg_wdata_in = data;
        reg_wr_in = 1'b1;
        tick(1);
        reg_wr_in = 1'b0;
        for (i = 0; i < 3 && wr_refused_out !== 1'b1 &&
             nv_store_req_out !== 1'b1; i++) tick(1);
        check({6'h00, wr_refused_out, nv_store_req_out}, {6'h00, rsp});
    endtask

    task automatic run_seq;
        seq_start_in = 1'b1;
        tick(1);
        seq_start_in = 1'b0;
        for (k = 0; k < 200 && seq_done_out !== 1'b1; k++) tick(1);
        if (seq_done_out !== 1'b1) timeout();
    endtask

    ////////////////////////////////////////////////////////////////////////
    // seal status unread
    initial begin
        n_errors = 0; checks = 0; rstn_in = 1'b0; reg_wr_in = 1'b0;
        reg_rd_in = 1'b0; pw_unlocked_in = 1'b1; nv_load_in = 1'b0;
        seq_start_in = 1'b0; seq_down_in = 1'b0; out1_manual_in = 1'b0;
        out3_manual_in = 1'b0; reg_addr_in = 8'h00; reg_wdata_in = 8'h00;
        nv_data_in = 8'h00;
        tick(2);
        rstn_in = 1'b1;
        tick(1);
        check1(out1_seq_ctl_out, 1'b1);
        check1(out3_seq_ctl_out, 1'b0);
        reg_read(8'h26, 8'h03);
        out1_manual_in = 1'b1;
        out3_manual_in = 1'b1;
        tick(2);
        check1(general_output_three_out, 1'b1);
        check1(general_output_one_out, 1'b0);
        out1_manual_in = 1'b0;
        out3_manual_in = 1'b0;
        pw_unlocked_in = 1'b0;
        reg_write(8'h26, 8'h5a, 2'b10);
        pw_unlocked_in = 1'b1;
        reg_read(8'h26, 8'h03);
        reg_write(8'h25, 8'hff, 2'b00);
        reg_read(8'h27, 8'h00);
        reg_read(8'h26, 8'h03);
        for (c = 0; c < 16; c++) begin
            reg_write(8'h26, {c[3:0], ~c[3:0]}, 2'b01);
            reg_read(8'h26, {c[3:0], ~c[3:0]});
            check1(out3_seq_ctl_out, c >= 3 && c <= 10);
            check1(out1_seq_ctl_out, c >= 5 && c <= 12);
        end
        out1_manual_in = 1'b1;
        tick(2);
        check1(general_output_one_out, 1'b1);
        out1_manual_in = 1'b0;
        nv_data_in = 8'h97;
        nv_load_in = 1'b1;
        tick(1);
        nv_load_in = 1'b0;
        reg_read(8'h26, 8'h97);
        reg_write(8'h26, 8'h53, 2'b01);
        seq_start_in = 1'b1;
        tick(1);
        seq_start_in = 1'b0;
        for (t1 = 0; t1 < 200 && general_output_one_out !== 1'b1; t1++)
            tick(1);
        if (general_output_one_out !== 1'b1) timeout();
        check(8'(t1), 8'(STEP_P + 1));
        check1(seq_busy_out, 1'b1);
        check1(general_output_three_out, 1'b0);
        for (t3 = t1; t3 < 400 && general_output_three_out !== 1'b1; t3++)
            tick(1);
        if (general_output_three_out !== 1'b1) timeout();
        check(8'(t3 - t1), 8'(2 * (STEP_P + 1)));
        run_seq();
        tick(2);
        check1(general_output_one_out, 1'b1);
        check1(general_output_three_out, 1'b1);
        check1(seq_busy_out, 1'b0);
        seq_down_in = 1'b1;
        tick(2);
        seq_down_in = 1'b0;
        check1(general_output_one_out, 1'b0);
        check1(seq_done_out, 1'b0);
        reg_write(8'h26, 8'hb3, 2'b01);
        run_seq();
        tick(2);
        check1(general_output_three_out, 1'b0);
        check1(general_output_one_out, 1'b1);
        conclude();
    end

    initial begin
        #100000;
        timeout();
    end
endmodule
